// ---- rtl/adc_input_setup_register.sv ----
// Input setup register, conversion pacing and samples-ready pulse.
`timescale 1ns/1ps
module adc_input_setup_register
    import adc_setup_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [11:0] i_data_bus,
    input wire logic i_write_n,
    input wire logic i_conversion_clock_in,
    input wire logic [3:0] i_trigger_level,
    output logic [9:0] o_setup_value,
    output logic o_reference_select,
    output logic o_single_mode,
    output logic o_power_down_bit,
    output logic [1:0] o_channel_pick,
    output logic [1:0] o_differential_count,
    output logic o_sweep_enable,
    output logic [1:0] o_reference_check,
    output logic o_hold_strobe,
    output logic o_fifo_write,
    output logic o_samples_ready_flag_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_s1;
        logic wr_s2;
        logic wr_prev;
        logic [11:0] data_s1;
        logic [11:0] data_s2;
        logic cc_s1;
        logic cc_s2;
        logic cc_prev;
        logic [9:0] setup;
        logic [3:0] fill_count;
        logic hold_strobe;
        logic fifo_write;
        logic ready_n;
    } state_t;

    state_t st;
    state_t next_st;

    // Rising edge of a synchronised level against its previous sample.
    function automatic logic rose(input logic prev, input logic cur);
        rose = cur & ~prev;
    endfunction

    // Falling edge of a synchronised level against its previous sample.
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Pins pass two flops first; the write is taken at the end of the
    // strobe so the data has settled through the same two stages.
    always_comb begin
        logic take_write;
        logic conv_edge;
        logic [3:0] level;
        logic [3:0] filled;
        take_write = 1'b0;
        conv_edge = 1'b0;
        level = 4'h0;
        filled = 4'h0;
        next_st = st;
        next_st.wr_s1 = i_write_n;
        next_st.wr_s2 = st.wr_s1;
        next_st.wr_prev = st.wr_s2;
        next_st.data_s1 = i_data_bus;
        next_st.data_s2 = st.data_s1;
        next_st.cc_s1 = i_conversion_clock_in;
        next_st.cc_s2 = st.cc_s1;
        next_st.cc_prev = st.cc_s2;
        next_st.hold_strobe = 1'b0;
        next_st.fifo_write = 1'b0;
        next_st.ready_n = 1'b1;

        // Writes are honoured in power down as well.
        take_write = rose(st.wr_prev, st.wr_s2) &&
            st.data_s2[SELECT_MSB:SELECT_LSB] == SETUP_SELECT_CODE;
        if (take_write) begin
            next_st.setup = st.data_s2[9:0];
        end

        // Powered down, edges on the conversion pin are ignored.
        conv_edge = fell(st.cc_prev, st.cc_s2) &&
            !st.setup[POWER_DOWN_BIT];
        if (conv_edge) begin
            next_st.fifo_write = 1'b1;
            // Single mode: the edge is a trigger and freezes every
            // selected input at once.
            next_st.hold_strobe = st.setup[MODE_BIT];
        end

        // A level of zero is not legal; treat it as one so the flag
        // can never stall forever.
        level = (i_trigger_level == 4'h0) ? 4'h1 : i_trigger_level;
        if (st.fifo_write) begin
            filled = st.fill_count + 4'h1;
            if (filled >= level) begin
                next_st.fill_count = FILL_RESET;
                // One-cycle low pulse, held off in test mode.
                next_st.ready_n = (st.setup[REF_CHECK_LSB +: 2] != 2'h0);
            end else begin
                next_st.fill_count = filled;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
            st.wr_s1 <= 1'b1;
            st.wr_s2 <= 1'b1;
            st.wr_prev <= 1'b1;
            st.setup <= SETUP_RESET;
            st.ready_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    // Field outputs steer the analog side; readback stays live in
    // power down.
    assign o_setup_value = st.setup;
    assign o_reference_select = st.setup[REF_SELECT_BIT];
    assign o_single_mode = st.setup[MODE_BIT];
    assign o_power_down_bit = st.setup[POWER_DOWN_BIT];
    assign o_channel_pick = st.setup[CHANNEL_PICK_LSB +: 2];
    assign o_differential_count = st.setup[DIFF_COUNT_LSB +: 2];
    assign o_sweep_enable = st.setup[SWEEP_ENABLE_BIT];
    assign o_reference_check = st.setup[REF_CHECK_LSB +: 2];
    assign o_hold_strobe = st.hold_strobe;
    assign o_fifo_write = st.fifo_write;
    assign o_samples_ready_flag_n = st.ready_n;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_write_taken;
        st.wr_s2 && !st.wr_prev &&
            st.data_s2[SELECT_MSB:SELECT_LSB] == SETUP_SELECT_CODE;
    endsequence

    sequence s_conv_edge;
        !st.cc_s2 && st.cc_prev && !st.setup[POWER_DOWN_BIT];
    endsequence

    property p_write_store;
        s_write_taken |=> o_setup_value == $past(st.data_s2[9:0]);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("Selected write was not stored.");

    property p_other_select;
        (st.wr_s2 && !st.wr_prev &&
            st.data_s2[SELECT_MSB:SELECT_LSB] != SETUP_SELECT_CODE)
            |=> $stable(o_setup_value);
    endproperty
    a_other_select: assert property (p_other_select)
        else $error("Write to another register changed the setup.");

    property p_cont_write;
        (s_conv_edge ##0 !st.setup[MODE_BIT])
            |=> o_fifo_write && !o_hold_strobe;
    endproperty
    a_cont_write: assert property (p_cont_write)
        else $error("Continuous edge gave no single FIFO write.");

    property p_single_hold;
        (s_conv_edge ##0 st.setup[MODE_BIT])
            |=> o_hold_strobe && o_fifo_write;
    endproperty
    a_single_hold: assert property (p_single_hold)
        else $error("Trigger edge did not hold and convert.");

    property p_pd_idle;
        o_fifo_write |-> !$past(st.setup[POWER_DOWN_BIT]);
    endproperty
    a_pd_idle: assert property (p_pd_idle)
        else $error("Conversion ran while powered down.");

    property p_test_quiet;
        !o_samples_ready_flag_n |-> $past(st.setup[9:8]) == 2'h0;
    endproperty
    a_test_quiet: assert property (p_test_quiet)
        else $error("Samples-ready pulsed in test mode.");

    property p_ready_pulse;
        !o_samples_ready_flag_n |=> o_samples_ready_flag_n;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("Samples-ready stayed low over one cycle.");

    property p_ready_cause;
        !o_samples_ready_flag_n |->
            $past(o_fifo_write) && st.fill_count == FILL_RESET;
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("Samples-ready without a completing write.");

    property p_level_one;
        (o_fifo_write && i_trigger_level == 4'h1 &&
            st.setup[9:8] == 2'h0) |=> !o_samples_ready_flag_n;
    endproperty
    a_level_one: assert property (p_level_one)
        else $error("Level one did not pulse after each write.");

endmodule

// ---- rtl/adc_setup_pkg.sv ----
// Constants for the converter input setup register block.
package adc_setup_pkg;
    // Register select code carried on the two upper data-bus bits.
    localparam logic [1:0] SETUP_SELECT_CODE = 2'h0;
    localparam int SELECT_LSB = 10;
    localparam int SELECT_MSB = 11;
    // Field positions inside the setup register.
    localparam int REF_SELECT_BIT = 0;
    localparam int MODE_BIT = 1;
    localparam int POWER_DOWN_BIT = 2;
    localparam int CHANNEL_PICK_LSB = 3;
    localparam int DIFF_COUNT_LSB = 5;
    localparam int SWEEP_ENABLE_BIT = 7;
    localparam int REF_CHECK_LSB = 8;
    // Reset value: only the low differential-count bit is set.
    localparam logic [9:0] SETUP_RESET = 10'h020;
    // Fill counter reset value.
    localparam logic [3:0] FILL_RESET = 4'h0;
endpackage

// ---- test/host_model.sv ----
// Host processor model driving the parallel bus and conversion pin.
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk_sys,
    output logic [11:0] o_data_bus,
    output logic o_write_n,
    output logic o_conv_pin
);
    // Idle bus: strobe high, pin low, so reset sees no edges.
    initial begin
        o_data_bus = 12'h000;
        o_write_n = 1'b1;
        o_conv_pin = 1'b0;
    end
    // Select code rides on the two upper bits above the value.
    task automatic write_reg(input logic [1:0] sel, input logic [9:0] val);
        @(posedge i_clk_sys);
        o_data_bus <= {sel, val};
        o_write_n <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        o_write_n <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        // A released bus shows the inverse, so a late sample is caught.
        o_data_bus <= ~o_data_bus;
        repeat (3) @(posedge i_clk_sys);
    endtask
    // Each pin pulse is one conversion trigger or clock period.
    task automatic pulse_conv(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            o_conv_pin <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            o_conv_pin <= 1'b0;
            repeat (3) @(posedge i_clk_sys);
        end
        repeat (8) @(posedge i_clk_sys);
    endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the converter input setup register.
`timescale 1ns/1ps
module testbench;
    import adc_setup_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] lvl = 4'h1;
    logic [11:0] bus;
    logic wn, conv, rs, sm, pd, se, hs, fw, fl;
    logic [1:0] cp, dc, rc;
    logic [9:0] sv, cur;
    logic [9:0] rows [6] = '{10'h020, 10'h022, 10'h122, 10'h226, 10'h320,
        10'h021};
    int error_cnt = 0, checks_done = 0, n_wr = 0, n_hold = 0, n_flag = 0;
    int k;
    always #4 i_clk_sys = ~i_clk_sys;
    host_model host (.i_clk_sys(i_clk_sys), .o_data_bus(bus),
        .o_write_n(wn), .o_conv_pin(conv));
    adc_input_setup_register DUT (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_data_bus(bus), .i_write_n(wn),
        .i_conversion_clock_in(conv), .i_trigger_level(lvl),
        .o_setup_value(sv), .o_reference_select(rs), .o_single_mode(sm),
        .o_power_down_bit(pd), .o_channel_pick(cp),
        .o_differential_count(dc), .o_sweep_enable(se),
        .o_reference_check(rc), .o_hold_strobe(hs), .o_fifo_write(fw),
        .o_samples_ready_flag_n(fl));
    // ----------------------------------------
    // Pulse counters and checking helpers
    // ----------------------------------------
    // Pulses last one cycle, so they are counted at every edge.
    always @(posedge i_clk_sys) begin
        if (fw === 1'b1) n_wr++;
        if (hs === 1'b1) n_hold++;
        if (fl === 1'b0) n_flag++;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
        input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Flags expected: one per full block, none in test or power down.
    function automatic int exp_flags(input int n, input logic [9:0] s);
        if (s[REF_CHECK_LSB+:2] != 2'h0 || s[POWER_DOWN_BIT]) return 0;
        return n / ((lvl == 4'h0) ? 1 : int'(lvl));
    endfunction
    task automatic check_regs();
        logic [11:0] f;
        f = {2'h0, rc, se, dc, cp, pd, sm, rs};
        chk({2'h0, sv}, {2'h0, cur}, "readback");
        chk(f, {2'h0, cur}, "fields");
    endtask
    task automatic wr(input logic [1:0] sel, input logic [9:0] val);
        host.write_reg(sel, val);
        if (sel == SETUP_SELECT_CODE) cur = val;
        check_regs();
    endtask
    task automatic burst(input int n);
        int w0, h0, f0, ew, eh, ef;
        w0 = n_wr;
        h0 = n_hold;
        f0 = n_flag;
        ew = cur[POWER_DOWN_BIT] ? 0 : n;
        eh = cur[MODE_BIT] ? ew : 0;
        ef = exp_flags(n, cur);
        host.pulse_conv(n);
        chk(12'(n_wr - w0), 12'(ew), "writes");
        chk(12'(n_hold - h0), 12'(eh), "holds");
        chk(12'(n_flag - f0), 12'(ef), "flags");
    endtask
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        k = $urandom(32'hB1A5);
        cur = SETUP_RESET;
        repeat (5) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        check_regs();
        chk({11'h0, fl}, 12'h001, "flag idle");
        for (k = 0; k < 12; k++) begin
            wr(2'($urandom), 10'($urandom));
        end
        for (k = 1; k < 4; k++) begin
            wr(2'(k), ~cur);
        end
        // Rows: continuous, single, test voltages, power down, test voltages, back to normal.
        // The last row drives a level of zero, which must count as one.
        for (k = 0; k < 6; k++) begin
            lvl <= (k == 5) ? 4'h0 : 4'($urandom % 8 + 1);
            wr(2'h0, rows[k]);
            burst((k == 5) ? 4 : 2 * int'(lvl));
        end
        end_of_test();
    end
    // A hang is cut short well past the expected run length.
    initial begin
        repeat (30000) @(posedge i_clk_sys);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
